// ### bench/ftc_chk.sv
`default_nettype none
module ftc_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tx_take,
  input wire logic tx_serial,
  input wire logic tx_nrzi,
  input wire logic mlt_pos,
  input wire logic mlt_neg,
  input wire logic rx_pos,
  input wire logic rx_neg,
  input wire logic rx_nrzi,
  input wire logic rx_nibble_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic up;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ---
  // line coding
  // ---
  always_ff @(posedge ref_clk) up <= !rst && (mlt_pos || (up && !mlt_neg));
  property p_tk; tx_take |=> !tx_take [*4] ##1 tx_take; endproperty
  a_tk: assert property (p_tk) else $error("take gap");
  property p_nz; (tx_nrzi ^ $past(tx_nrzi)) == tx_serial; endproperty
  a_nz: assert property (p_nz) else $error("nrzi");
  property p_ex; !(mlt_pos && mlt_neg); endproperty
  a_ex: assert property (p_ex) else $error("both legs");
  property p_hd; $stable(tx_nrzi) |-> $stable({mlt_pos, mlt_neg}); endproperty
  a_hd: assert property (p_hd) else $error("level hold");
  property p_up; $changed(tx_nrzi) && !$past(mlt_pos) && !$past(mlt_neg)
    |-> mlt_pos != $past(up) && mlt_neg == $past(up); endproperty
  a_up: assert property (p_up) else $error("level step");
  property p_dn; $changed(tx_nrzi) && ($past(mlt_pos) || $past(mlt_neg))
    |-> !mlt_pos && !mlt_neg; endproperty
  a_dn: assert property (p_dn) else $error("to zero");
  property p_rc; $changed({rx_pos, rx_neg}) |=> $changed(rx_nrzi); endproperty
  a_rc: assert property (p_rc) else $error("rx nrzi");
  property p_rv;
    rx_nibble_valid |=> !rx_nibble_valid [*3] ##1 rx_nibble_valid;
  endproperty
  a_rv: assert property (p_rv) else $error("rx nibble gap");
  c_tk: cover property (tx_take);
  c_mn: cover property (mlt_neg);
  c_rv: cover property (rx_nibble_valid);
endmodule : ftc_chk
bind ftc_line_coder ftc_chk u_chk (.ref_clk, .rst, .tx_take, .tx_serial,
  .tx_nrzi, .mlt_pos, .mlt_neg, .rx_pos, .rx_neg, .rx_nrzi,
  .rx_nibble_valid);
`default_nettype wire

// ### bench/ftc_mac_model.sv
`default_nettype none
module ftc_mac_model (
  input wire logic ref_clk,
  input wire logic tx_take,
  input wire logic go,
  input wire logic [4:0] len,
  input wire logic mlt_pos,
  input wire logic mlt_neg,
  output logic tx_en,
  output logic [3:0] tx_nibble,
  output logic rx_pos,
  output logic rx_neg
);
  timeunit 1ns;
  timeprecision 1ns;
  int left;
  initial begin
    left = 0;
    tx_en = 1'b0;
    tx_nibble = 4'h0;
    rx_pos = 1'b0;
    rx_neg = 1'b0;
  end
  // ---
  // nibble source and line loopback
  // ---
  always @(negedge ref_clk) begin
    rx_pos <= mlt_pos;
    rx_neg <= mlt_neg;
    if (tx_take) begin
      if (left == 0 && go && !tx_en) left = len;
      tx_en <= left != 0;
      tx_nibble <= tx_nibble + 4'h1;
      if (left != 0) left--;
    end
  end
endmodule : ftc_mac_model
`default_nettype wire

// ### bench/test_fast_ether_tx_line_coder.sv
`default_nettype none
module test_fast_ether_tx_line_coder
  import ftc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, rst, tx_en, bypass, go, tx_take, tx_serial, tx_nrzi;
  logic mlt_pos, mlt_neg, rx_pos, rx_neg, rx_nrzi, rx_nibble_valid, pn;
  logic [3:0] tx_nibble, rx_nibble;
  logic [4:0] tx_code, len, g, w;
  logic [10:0] lf;
  logic q[$];
  logic [4:0] eg[$];
  int es[$];
  int st, cyc, n_mismatch, samples_checked;
  localparam logic [4:0] TB[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a,
    5'h0b, 5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c,
    5'h1d};
  ftc_line_coder dut (.ref_clk, .rst, .tx_en, .tx_nibble, .bypass,
    .tx_code, .tx_take, .tx_serial, .tx_nrzi, .mlt_pos, .mlt_neg, .rx_pos,
    .rx_neg, .rx_nrzi, .rx_nibble, .rx_nibble_valid);
  ftc_mac_model mac (.ref_clk, .tx_take, .go, .len, .mlt_pos, .mlt_neg,
    .tx_en, .tx_nibble, .rx_pos, .rx_neg);
  // ---
  // checks and scenarios
  // ---
  task automatic chk(input string nm, input logic [4:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  task automatic wen(input logic v);
    for (int n = 0; n < 400 && tx_en !== v; n++) @(negedge ref_clk);
    chk("tx_en", {4'h0, tx_en}, {4'h0, v});
  endtask : wen
  task automatic t_frame(input logic [4:0] n, input int k);
    len = n;
    go = 1'b1;
    repeat (k - 1) begin
      wen(1'b1);
      wen(1'b0);
    end
    wen(1'b1);
    go = 1'b0;
    wen(1'b0);
    repeat (20) @(negedge ref_clk);
  endtask : t_frame
  task automatic t_byp();
    for (int i = 0; i < 7; i++) begin
      do @(negedge ref_clk); while (tx_take !== 1'b1);
      bypass = i < 6;
      tx_code = 5'(i * 7);
    end
    repeat (10) @(negedge ref_clk);
  endtask : t_byp
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  always @(posedge ref_clk) begin
    if (rst) begin
      lf = LFSR_SEED;
      st = 0;
    end else if (tx_take) begin
      g = SYM_IDLE;
      if (st == 0 && tx_en) g = SYM_J;
      else if (st == 1) g = SYM_K;
      else if (st == 2 && tx_en) g = TB[tx_nibble];
      else if (st == 2) g = SYM_T;
      else if (st == 3) g = SYM_R;
      // one idle group always follows the end delimiter
      if (st == 4) st = 0;
      else if (g != SYM_IDLE && (st != 2 || !tx_en)) st++;
      if (bypass) g = tx_code;
      for (int i = 4; i >= 0; i--) begin
        g[i] = g[i] ^ lf[10] ^ lf[8];
        lf = {lf[9:0], lf[10] ^ lf[8]};
      end
      eg.push_back(g);
      es.push_back(q.size() + 1);
    end
  end
  always @(negedge ref_clk) begin
    q.push_back(tx_serial);
    if (!rst) chk("rx_nrzi", {4'h0, rx_nrzi}, {4'h0, pn});
    pn = tx_nrzi;
    // receive bits lag the transmitted serial bits by two clocks
    if (!rst && rx_nibble_valid && q.size() > 5) begin
      w = {1'b0, q[q.size()-6], q[q.size()-5], q[q.size()-4], q[q.size()-3]};
      chk("rx_nibble", {1'b0, rx_nibble}, w);
    end
    if (es.size() > 0 && q.size() >= es[0] + 5) begin
      for (int i = 0; i < 5; i++) w[4 - i] = q[es[0] + i];
      chk("group", w, eg.pop_front());
      void'(es.pop_front());
    end
  end
  initial begin
    rst = 1'b1;
    bypass = 1'b0;
    go = 1'b0;
    len = 5'h00;
    tx_code = 5'h00;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    repeat (30) @(negedge ref_clk);
    t_frame(5'h12, 1);
    t_frame(5'h03, 2);
    t_byp();
    end_of_test();
  end
endmodule : test_fast_ether_tx_line_coder
`default_nettype wire

// ### hdl/ftc_keystream.sv
`default_nettype none
module ftc_keystream
  import ftc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic advance,
  output logic [4:0] key
);

  // ---------------------------------------------------------------
  // five successive lfsr steps, first bit in key[4]
  // ---------------------------------------------------------------
  logic [10:0] lfsr;
  logic [10:0] stage [0:5];

  assign stage[0] = lfsr;

  genvar g;
  generate
    for (g = 0; g < SYM_W; g++) begin : g_step
      wire fb;
      assign fb = stage[g][LFSR_TAP_A] ^ stage[g][LFSR_TAP_B]; // RULE_14
      assign key[SYM_W-1-g] = fb;
      assign stage[g+1] = {stage[g][LFSR_W-2:0], fb}; // RULE_14
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lfsr <= LFSR_SEED;
    end else if (advance) begin
      lfsr <= stage[SYM_W]; // RULE_14
    end
  end

endmodule : ftc_keystream
`default_nettype wire

// ### hdl/ftc_line_coder.sv
// Function
// RULE_01: nibbles become code groups by table
// RULE_02: first two preamble nibbles become J, K
// RULE_03: later preamble and data nibbles are encoded
// RULE_04: enable drop appends T then R
// RULE_05: idle groups until next frame
// RULE_06: mac holds enable through the frame
// RULE_07: bypass passes supplied code groups unchanged
// RULE_08: keystream xor on every group, idle included; the reset idle group in shift goes out unscrambled
// RULE_09: scrambled group shifted out serially
// RULE_10: serial stream converted to nrzi
// RULE_11: two binary streams, alternating one events
// RULE_12: receive serial stream packed into nibbles
// RULE_13: three-level receive decoded back to nrzi
// RULE_14: keystream from x^11+x^9+1 lfsr
// RULE_15: nrzi toggles on one, holds on zero
// RULE_16: levels cycle zero, plus, zero, minus
`default_nettype none
module ftc_line_coder
  import ftc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tx_en,
  input wire logic [3:0] tx_nibble,
  input wire logic bypass,
  input wire logic [4:0] tx_code,
  output logic tx_take,
  output logic tx_serial,
  output logic tx_nrzi,
  output logic mlt_pos,
  output logic mlt_neg,
  input wire logic rx_pos,
  input wire logic rx_neg,
  output logic rx_nrzi,
  output logic [3:0] rx_nibble,
  output logic rx_nibble_valid
);

  // ---------------------------------------------------------------
  // group timing
  // ---------------------------------------------------------------
  logic [2:0] bit_cnt;
  wire load;
  wire [2:0] next_bit_cnt;

  assign load = (bit_cnt == BIT_LAST);
  assign next_bit_cnt = load ? BIT_FIRST : bit_cnt + 3'h1;
  // nibble is consumed in the cycle a group is chosen
  assign tx_take = load;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bit_cnt <= BIT_FIRST;
    end else begin
      bit_cnt <= next_bit_cnt;
    end
  end

  // ---------------------------------------------------------------
  // encoder framing
  // ---------------------------------------------------------------
  ftc_state_t state;
  ftc_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      FTC_IDLE: begin
        if (tx_en) begin
          next_state = FTC_J; // RULE_02
        end
      end
      FTC_J: begin
        next_state = FTC_K; // RULE_02
      end
      FTC_K, FTC_DATA: begin
        // enable is trusted to stay high for the whole frame
        if (tx_en) begin // RULE_06
          next_state = FTC_DATA; // RULE_03
        end else begin
          next_state = FTC_T; // RULE_04
        end
      end
      FTC_T: begin
        next_state = FTC_R; // RULE_04
      end
      FTC_R: begin
        next_state = FTC_IDLE; // RULE_05
      end
      default: begin
        next_state = FTC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= FTC_IDLE;
    end else if (load) begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // code group selection
  // ---------------------------------------------------------------
  wire [4:0] enc_code;
  logic [4:0] frame_code;
  wire [4:0] next_code;

  assign enc_code = ftc_enc(tx_nibble); // RULE_01

  always_comb begin
    case (next_state)
      FTC_IDLE: frame_code = SYM_IDLE; // RULE_05
      FTC_J: frame_code = SYM_J; // RULE_02
      FTC_K: frame_code = SYM_K; // RULE_02
      FTC_DATA: frame_code = enc_code; // RULE_03
      FTC_T: frame_code = SYM_T; // RULE_04
      FTC_R: frame_code = SYM_R; // RULE_04
      default: frame_code = SYM_IDLE;
    endcase
  end

  // repeater mode takes the supplied group as is
  assign next_code = bypass ? tx_code : frame_code; // RULE_07

  // ---------------------------------------------------------------
  // scrambler and serializer
  // ---------------------------------------------------------------
  wire [4:0] key;
  wire [4:0] scr_code;
  logic [4:0] shift;

  ftc_keystream u_key (
    .ref_clk(ref_clk),
    .rst(rst),
    .advance(load),
    .key(key)
  );

  assign scr_code = next_code ^ key; // RULE_08

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shift <= SYM_IDLE;
    end else if (load) begin
      shift <= scr_code; // RULE_09
    end else begin
      shift <= {shift[SYM_W-2:0], 1'b0}; // RULE_09
    end
  end

  // ---------------------------------------------------------------
  // nrzi and three-level drive
  // ---------------------------------------------------------------
  wire ser_bit;
  logic [1:0] phase;
  wire [1:0] next_phase;

  assign ser_bit = shift[SYM_W-1];
  assign next_phase = ser_bit ? phase + 2'h1 : phase; // RULE_16

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_serial <= 1'b0;
      tx_nrzi <= 1'b0;
      phase <= PH_ZERO_A;
      mlt_pos <= 1'b0;
      mlt_neg <= 1'b0;
    end else begin
      tx_serial <= ser_bit; // RULE_09
      tx_nrzi <= tx_nrzi ^ ser_bit; // RULE_10 RULE_15
      phase <= next_phase; // RULE_16
      mlt_pos <= (next_phase == PH_PLUS); // RULE_11
      mlt_neg <= (next_phase == PH_MINUS); // RULE_11
    end
  end

  // ---------------------------------------------------------------
  // receive: three-level to nrzi
  // ---------------------------------------------------------------
  logic rx_pos_q;
  logic rx_neg_q;
  wire rx_change;

  assign rx_change = (rx_pos != rx_pos_q) | (rx_neg != rx_neg_q);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_pos_q <= 1'b0;
      rx_neg_q <= 1'b0;
      rx_nrzi <= 1'b0;
    end else begin
      rx_pos_q <= rx_pos;
      rx_neg_q <= rx_neg;
      rx_nrzi <= rx_nrzi ^ rx_change; // RULE_13 RULE_15
    end
  end

  // ---------------------------------------------------------------
  // receive: nrzi to nrz and serial to nibble
  // ---------------------------------------------------------------
  logic rx_nrzi_q;
  logic [1:0] rx_cnt;
  logic [2:0] rx_sh;
  wire rx_bit;
  wire rx_full;

  assign rx_bit = rx_nrzi ^ rx_nrzi_q; // RULE_15
  assign rx_full = (rx_cnt == RX_NIB_LAST);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_nrzi_q <= 1'b0;
      rx_cnt <= 2'h0;
      rx_sh <= 3'h0;
      rx_nibble <= 4'h0;
      rx_nibble_valid <= 1'b0;
    end else begin
      rx_nrzi_q <= rx_nrzi;
      rx_cnt <= rx_cnt + 2'h1; // RULE_12
      rx_sh <= {rx_sh[1:0], rx_bit};
      rx_nibble_valid <= rx_full; // RULE_12
      if (rx_full) begin
        rx_nibble <= {rx_sh, rx_bit}; // RULE_12
      end
    end
  end

endmodule : ftc_line_coder
`default_nettype wire

// ### shared/ftc_pkg.sv
`default_nettype none
package ftc_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int NIB_W = 4;
  localparam int SYM_W = 5;
  localparam int LFSR_W = 11;
  localparam logic [2:0] BIT_LAST = 3'h4;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [1:0] RX_NIB_LAST = 2'h3;

  // ---------------------------------------------------------------
  // control code groups
  // ---------------------------------------------------------------
  localparam logic [4:0] SYM_IDLE = 5'h1f;
  localparam logic [4:0] SYM_J = 5'h18;
  localparam logic [4:0] SYM_K = 5'h11;
  localparam logic [4:0] SYM_T = 5'h0d;
  localparam logic [4:0] SYM_R = 5'h07;

  // ---------------------------------------------------------------
  // keystream generator
  // ---------------------------------------------------------------
  localparam int LFSR_TAP_A = 10;
  localparam int LFSR_TAP_B = 8;
  localparam logic [10:0] LFSR_SEED = 11'h7ff;

  // ---------------------------------------------------------------
  // three-level line phases
  // ---------------------------------------------------------------
  localparam logic [1:0] PH_ZERO_A = 2'h0;
  localparam logic [1:0] PH_PLUS = 2'h1;
  localparam logic [1:0] PH_ZERO_B = 2'h2;
  localparam logic [1:0] PH_MINUS = 2'h3;

  typedef enum logic [5:0] {
    FTC_IDLE = 6'h01,
    FTC_J = 6'h02,
    FTC_K = 6'h04,
    FTC_DATA = 6'h08,
    FTC_T = 6'h10,
    FTC_R = 6'h20
  } ftc_state_t;

  // data nibble to code group
  function automatic logic [4:0] ftc_enc(input logic [3:0] nib);
    logic [4:0] s;
    s = SYM_IDLE;
    case (nib)
      4'h0: s = 5'h1e;
      4'h1: s = 5'h09;
      4'h2: s = 5'h14;
      4'h3: s = 5'h15;
      4'h4: s = 5'h0a;
      4'h5: s = 5'h0b;
      4'h6: s = 5'h0e;
      4'h7: s = 5'h0f;
      4'h8: s = 5'h12;
      4'h9: s = 5'h13;
      4'ha: s = 5'h16;
      4'hb: s = 5'h17;
      4'hc: s = 5'h1a;
      4'hd: s = 5'h1b;
      4'he: s = 5'h1c;
      4'hf: s = 5'h1d;
      default: s = SYM_IDLE;
    endcase
    return s;
  endfunction : ftc_enc

endpackage : ftc_pkg
`default_nettype wire
